// ==== logic/rcc_reset_ctrl.v ====
// reset cause controller: merges reset sources, records causes, drives peripheral resets
// What this block does
// RULE_01: internal system reset comes from pin, power-on, brown-out, software or watchdog.
// RULE_02: each reset sets its cause bit; cause bits survive later resets.
// RULE_03: a power-on reset clears all cause bits except the power-on bit.
// RULE_04: pin reset resets core and peripherals but not the test access port.
// RULE_05: after release the core fetches stack pointer, program counter, instruction, then runs.
// RULE_06: pin release is synchronised and a few cycles pass before the sequence.
// RULE_07: at power-up reset holds until both pin and power-on detector are inactive.
// RULE_08: power-on detection acts only at the first power-up, never again.
// RULE_09: power-on reset also resets the test access port controller.
// RULE_10: brown-out reset is off after reset until software enables it.
// RULE_11: brown-out resets only with the select bit set, otherwise raises an interrupt.
// RULE_12: brown-out reset acts like pin reset and holds while the brown-out lasts.
// RULE_13: three peripheral reset registers; set then clear a bit to reset a peripheral.
// RULE_14: peripheral reset bit positions match the peripheral clock gating bit positions.
// RULE_15: a peripheral reset asserts the reset of every clock domain of that unit.
// RULE_16: a core reset request asserts, then releases reset with a normal boot fetch.
// RULE_17: watchdog interrupts on first time-out and may reset on the second.
// RULE_18: after the first time-out the 32-bit counter reloads from the load value.
// RULE_19: watchdog resets only if enabled and it expires before the interrupt is cleared.
// RULE_20: cause register has one bit per source; writing zeros clears bits.
`timescale 1ns/1ns
`include "rcc_consts.vh"

module rcc_reset_ctrl #(
  parameter NUM_DOMAINS = 2,
  parameter PRST_W      = 32
) (
  // clock and reset
  input  wire                              aclk,
  input  wire                              aresetn,
  // axi4-lite write channels
  input  wire [`RCC_ADDR_W-1:0]            s_axi_awaddr,
  input  wire [2:0]                        s_axi_awprot,
  input  wire                              s_axi_awvalid,
  output wire                              s_axi_awready,
  input  wire [31:0]                       s_axi_wdata,
  input  wire [3:0]                        s_axi_wstrb,
  input  wire                              s_axi_wvalid,
  output wire                              s_axi_wready,
  output reg  [1:0]                        s_axi_bresp,
  output reg                               s_axi_bvalid,
  input  wire                              s_axi_bready,
  // axi4-lite read channels
  input  wire [`RCC_ADDR_W-1:0]            s_axi_araddr,
  input  wire [2:0]                        s_axi_arprot,
  input  wire                              s_axi_arvalid,
  output wire                              s_axi_arready,
  output reg  [31:0]                       s_axi_rdata,
  output reg  [1:0]                        s_axi_rresp,
  output reg                               s_axi_rvalid,
  input  wire                              s_axi_rready,
  // reset sources
  input  wire                              rst_pin_n,
  input  wire                              por_detect,
  input  wire                              brown_out_detect,
  input  wire                              system_reset_request,
  // reset and boot outputs
  output reg                               core_reset_n,
  output reg                               periph_reset_n,
  output reg                               tap_reset_n,
  output reg                               boot_fetch_sp,
  output reg                               boot_fetch_pc,
  output reg                               boot_fetch_insn,
  output reg                               core_run,
  output wire [NUM_DOMAINS*3*PRST_W-1:0]   periph_unit_reset,
  // event outputs
  output reg                               brownout_int,
  output wire                              watchdog_int
);

  // --------------------------------------------------------------------------
  // sequencer states
  // --------------------------------------------------------------------------
  localparam [2:0] S_HOLD    = 3'h0;
  localparam [2:0] S_STRETCH = 3'h1;
  localparam [2:0] S_SP      = 3'h2;
  localparam [2:0] S_PC      = 3'h3;
  localparam [2:0] S_INSN    = 3'h4;
  localparam [2:0] S_RUN     = 3'h5;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // byte-lane merge, used by every writable register
  function [31:0] strb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      i;
    begin
      strb_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // mapped-address check, shared by read and write decode
  function addr_ok;
    input [`RCC_ADDR_W-1:0] a;
    begin
      addr_ok = (a <= `RCC_OFS_STATUS) && (a[1:0] == 2'b00);
    end
  endfunction

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  reg                      pin_s1_r, pin_s2_r;
  reg                      por_s1_r, por_s2_r;
  reg                      bor_s1_r, bor_s2_r;
  reg  [2:0]               state_r, state_nxt;
  reg  [3:0]               stretch_cnt_r, stretch_cnt_nxt;
  reg  [3:0]               pulse_cnt_r;
  reg                      por_armed_r;
  reg  [`RCC_CAUSE_W-1:0]  cause_r, cause_nxt;
  reg  [2:0]               borctl_r;
  reg                      bor_prev_r;
  reg  [PRST_W-1:0]        prst0_r, prst1_r, prst2_r;
  reg  [31:0]              wd_load_r, wd_cnt_r;
  reg  [1:0]               wd_ctl_r;
  reg                      wd_int_r;
  reg                      wd_rst_r;
  reg                      aw_hold_r, w_hold_r;
  reg  [`RCC_ADDR_W-1:0]   aw_addr_r;
  reg  [31:0]              w_data_r;
  reg  [3:0]               w_strb_r;
  reg  [31:0]              rd_data;
  wire                     ext_act, por_act, bor_act, bor_rst_act, bor_irq_act;
  wire                     sw_req, any_src, sys_rst, regs_rst;
  wire                     wr_fire, rd_fire;
  wire [31:0]              wmerge_cause, wmerge_bor, wmerge_p0, wmerge_p1, wmerge_p2;
  wire [31:0]              wmerge_wl, wmerge_wc;
  wire                     wd_expire;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  // pin and monitors are asynchronous; two flops each before any use
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      por_s1_r <= 1'b1;
      por_s2_r <= 1'b1;
      bor_s1_r <= 1'b0;
      bor_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= rst_pin_n;
      pin_s2_r <= pin_s1_r;    // RULE_06
      por_s1_r <= por_detect;
      por_s2_r <= por_s1_r;
      bor_s1_r <= brown_out_detect;
      bor_s2_r <= bor_s1_r;
    end
  end

  // --------------------------------------------------------------------------
  // reset source merge
  // --------------------------------------------------------------------------
  assign ext_act     = !pin_s2_r;
  assign por_act     = por_armed_r && por_s2_r;                      // RULE_08
  assign bor_act     = borctl_r[`RCC_BOR_EN] && bor_s2_r;            // RULE_10
  assign bor_rst_act = bor_act && borctl_r[`RCC_BOR_SEL];            // RULE_11 RULE_12
  assign bor_irq_act = bor_act && !borctl_r[`RCC_BOR_SEL];           // RULE_11
  assign sw_req      = system_reset_request && (state_r == S_RUN);   // RULE_16
  // level sources hold reset for as long as they last; pulses are stretched
  assign any_src     = ext_act || por_act || bor_rst_act || (pulse_cnt_r != 4'h0); // RULE_01 RULE_07
  assign sys_rst     = (state_r == S_HOLD) || (state_r == S_STRETCH);
  assign regs_rst    = !aresetn || sys_rst;

  // pulse sources (core request, watchdog) keep reset asserted a few cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt_r <= 4'h0;
    end else if (sw_req || wd_rst_r) begin
      pulse_cnt_r <= `RCC_PULSE_CYCLES;      // RULE_16
    end else if (pulse_cnt_r != 4'h0) begin
      pulse_cnt_r <= pulse_cnt_r - 4'h1;
    end
  end

  // the detector is honoured only until the first release after power-up
  always @(posedge aclk) begin
    if (!aresetn) begin
      por_armed_r <= 1'b1;
    end else if (state_r == S_SP) begin
      por_armed_r <= 1'b0;                   // RULE_08
    end
  end

  // --------------------------------------------------------------------------
  // reset and boot sequencer
  // --------------------------------------------------------------------------
  // any active source returns to hold, so a glitch mid-boot restarts cleanly
  always @* begin
    state_nxt       = state_r;
    stretch_cnt_nxt = stretch_cnt_r;
    case (state_r)
      S_HOLD: begin
        if (!any_src) begin
          state_nxt       = S_STRETCH;
          stretch_cnt_nxt = `RCC_SYNC_CYCLES;   // RULE_06
        end
      end
      S_STRETCH: begin
        if (stretch_cnt_r == 4'h1) begin
          state_nxt = S_SP;
        end else begin
          stretch_cnt_nxt = stretch_cnt_r - 4'h1;
        end
      end
      S_SP:    state_nxt = S_PC;                // RULE_05
      S_PC:    state_nxt = S_INSN;              // RULE_05
      S_INSN:  state_nxt = S_RUN;               // RULE_05
      S_RUN:   state_nxt = S_RUN;
      default: state_nxt = S_HOLD;
    endcase
    if (any_src) begin
      state_nxt = S_HOLD;                       // RULE_01 RULE_12
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r       <= S_HOLD;
      stretch_cnt_r <= 4'h0;
    end else begin
      state_r       <= state_nxt;
      stretch_cnt_r <= stretch_cnt_nxt;
    end
  end

  // registered reset and boot outputs, one cycle after the state
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_reset_n    <= 1'b0;
      periph_reset_n  <= 1'b0;
      tap_reset_n     <= 1'b0;
      boot_fetch_sp   <= 1'b0;
      boot_fetch_pc   <= 1'b0;
      boot_fetch_insn <= 1'b0;
      core_run        <= 1'b0;
    end else begin
      core_reset_n    <= !sys_rst;              // RULE_04
      periph_reset_n  <= !sys_rst;              // RULE_04
      tap_reset_n     <= !por_act;              // RULE_04 RULE_09
      boot_fetch_sp   <= (state_r == S_SP);     // RULE_05
      boot_fetch_pc   <= (state_r == S_PC);     // RULE_05
      boot_fetch_insn <= (state_r == S_INSN);   // RULE_05
      core_run        <= (state_r == S_RUN);
    end
  end

  // --------------------------------------------------------------------------
  // bus write side
  // --------------------------------------------------------------------------
  // address and data are parked independently; one response at a time
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_fire       = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= {`RCC_ADDR_W{1'b0}};
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RCC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(aw_addr_r) ? `RCC_RESP_OKAY : `RCC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // strobed write values for each register
  assign wmerge_cause = strb_merge({27'h0, cause_r}, w_data_r, w_strb_r);
  assign wmerge_bor   = strb_merge({29'h0, borctl_r}, w_data_r, w_strb_r);
  assign wmerge_p0    = strb_merge(prst0_r, w_data_r, w_strb_r);
  assign wmerge_p1    = strb_merge(prst1_r, w_data_r, w_strb_r);
  assign wmerge_p2    = strb_merge(prst2_r, w_data_r, w_strb_r);
  assign wmerge_wl    = strb_merge(wd_load_r, w_data_r, w_strb_r);
  assign wmerge_wc    = strb_merge({30'h0, wd_ctl_r}, w_data_r, w_strb_r);

  // --------------------------------------------------------------------------
  // reset cause register
  // --------------------------------------------------------------------------
  // only the logic power-up clears it; a hardware set beats a software clear
  always @* begin
    cause_nxt = cause_r;
    if (wr_fire && (aw_addr_r == `RCC_OFS_CAUSE)) begin
      cause_nxt = cause_r & wmerge_cause[`RCC_CAUSE_W-1:0];      // RULE_20
    end
    if (ext_act)     cause_nxt[`RCC_C_EXT] = 1'b1;              // RULE_02
    if (bor_rst_act) cause_nxt[`RCC_C_BOR] = 1'b1;              // RULE_02
    if (sw_req)      cause_nxt[`RCC_C_SW]  = 1'b1;              // RULE_02
    if (wd_rst_r)    cause_nxt[`RCC_C_WD]  = 1'b1;              // RULE_02
    if (por_act) begin
      cause_nxt = `RCC_CAUSE_PORONLY;                           // RULE_03
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= `RCC_CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // brown-out control and peripheral reset registers
  // --------------------------------------------------------------------------
  // cleared by system reset so brown-out reset starts disabled, but not while a
  // brown-out reset holds: clearing the enable then would end that reset early
  always @(posedge aclk) begin
    if (!aresetn || (sys_rst && !bor_rst_act)) begin           // RULE_10 RULE_12
      borctl_r   <= 3'h0;                                      // RULE_10
      bor_prev_r <= 1'b0;
      brownout_int <= 1'b0;
      prst0_r    <= {PRST_W{1'b0}};
      prst1_r    <= {PRST_W{1'b0}};
      prst2_r    <= {PRST_W{1'b0}};
    end else begin
      bor_prev_r   <= bor_irq_act;
      brownout_int <= bor_irq_act && !bor_prev_r;              // RULE_11
      if (wr_fire && (aw_addr_r == `RCC_OFS_BORCTL)) begin
        borctl_r[`RCC_BOR_EN]  <= wmerge_bor[`RCC_BOR_EN];
        borctl_r[`RCC_BOR_SEL] <= wmerge_bor[`RCC_BOR_SEL];
      end
      // flag: write one clears, a new event in the same cycle wins
      if (bor_irq_act && !bor_prev_r) begin
        borctl_r[`RCC_BOR_FLAG] <= 1'b1;                       // RULE_11
      end else if (wr_fire && (aw_addr_r == `RCC_OFS_BORCTL) && w_data_r[`RCC_BOR_FLAG]
                   && w_strb_r[0]) begin
        borctl_r[`RCC_BOR_FLAG] <= 1'b0;
      end
      // a unit stays in reset while its bit is set; clearing ends it
      if (wr_fire && (aw_addr_r == `RCC_OFS_PRST0)) prst0_r <= wmerge_p0[PRST_W-1:0]; // RULE_13
      if (wr_fire && (aw_addr_r == `RCC_OFS_PRST1)) prst1_r <= wmerge_p1[PRST_W-1:0]; // RULE_13
      if (wr_fire && (aw_addr_r == `RCC_OFS_PRST2)) prst2_r <= wmerge_p2[PRST_W-1:0]; // RULE_13
    end
  end

  // bit n of each register drives the same unit as clock gate bit n, in every domain
  genvar gd;
  generate
    for (gd = 0; gd < NUM_DOMAINS; gd = gd + 1) begin : g_dom
      assign periph_unit_reset[gd*3*PRST_W +: 3*PRST_W] = {prst2_r, prst1_r, prst0_r}; // RULE_14 RULE_15
    end
  endgenerate

  // --------------------------------------------------------------------------
  // watchdog
  // --------------------------------------------------------------------------
  // second expiry with the interrupt still pending is the reset condition
  assign wd_expire    = wd_ctl_r[`RCC_WD_RUN] && (wd_cnt_r == 32'h0);
  assign watchdog_int = wd_int_r;

  always @(posedge aclk) begin
    if (regs_rst) begin
      wd_load_r <= `RCC_WD_LOAD_RST;
      wd_cnt_r  <= `RCC_WD_LOAD_RST;
      wd_ctl_r  <= 2'h0;
      wd_int_r  <= 1'b0;
      wd_rst_r  <= 1'b0;
    end else begin
      wd_rst_r <= 1'b0;
      if (wr_fire && (aw_addr_r == `RCC_OFS_WDCTL)) begin
        wd_ctl_r <= wmerge_wc[1:0];
      end
      if (wr_fire && (aw_addr_r == `RCC_OFS_WDLOAD)) begin
        wd_load_r <= wmerge_wl;
        wd_cnt_r  <= wmerge_wl;
      end else if (wd_expire) begin
        wd_cnt_r <= wd_load_r;                                 // RULE_18
      end else if (wd_ctl_r[`RCC_WD_RUN]) begin
        wd_cnt_r <= wd_cnt_r - 32'h1;
      end
      if (wd_expire && !wd_int_r) begin
        wd_int_r <= 1'b1;                                      // RULE_17
      end else if (wd_expire && wd_int_r) begin
        wd_rst_r <= wd_ctl_r[`RCC_WD_RSTEN];                   // RULE_17 RULE_19
      end else if (wr_fire && (aw_addr_r == `RCC_OFS_WDCLR)) begin
        wd_int_r <= 1'b0;                                      // RULE_19
      end
    end
  end

  // --------------------------------------------------------------------------
  // bus read side
  // --------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  // read mux; unmapped words read zero
  always @* begin
    rd_data = 32'h0;
    case (s_axi_araddr)
      `RCC_OFS_CAUSE:  rd_data = {27'h0, cause_r};
      `RCC_OFS_BORCTL: rd_data = {29'h0, borctl_r};
      `RCC_OFS_PRST0:  rd_data = {{(32-PRST_W){1'b0}}, prst0_r};
      `RCC_OFS_PRST1:  rd_data = {{(32-PRST_W){1'b0}}, prst1_r};
      `RCC_OFS_PRST2:  rd_data = {{(32-PRST_W){1'b0}}, prst2_r};
      `RCC_OFS_WDLOAD: rd_data = wd_load_r;
      `RCC_OFS_WDCTL:  rd_data = {29'h0, wd_int_r, wd_ctl_r};
      `RCC_OFS_WDVAL:  rd_data = wd_cnt_r;
      `RCC_OFS_STATUS: rd_data = {26'h0, state_r, por_armed_r, bor_s2_r, pin_s2_r};
      default:         rd_data = 32'h0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RCC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= addr_ok(s_axi_araddr) ? `RCC_RESP_OKAY : `RCC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== logic/rcc_consts.vh ====
// register map, field positions, reset values and counts of the reset cause controller
`ifndef RCC_CONSTS_VH
`define RCC_CONSTS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RCC_ADDR_W        8
`define RCC_OFS_CAUSE     8'h00
`define RCC_OFS_BORCTL    8'h04
`define RCC_OFS_PRST0     8'h08
`define RCC_OFS_PRST1     8'h0c
`define RCC_OFS_PRST2     8'h10
`define RCC_OFS_WDLOAD    8'h14
`define RCC_OFS_WDCTL     8'h18
`define RCC_OFS_WDVAL     8'h1c
`define RCC_OFS_WDCLR     8'h20
`define RCC_OFS_STATUS    8'h24

// ----------------------------------------------------------------------------
// reset cause fields
// ----------------------------------------------------------------------------
`define RCC_CAUSE_W       5
`define RCC_C_EXT         0
`define RCC_C_POR         1
`define RCC_C_BOR         2
`define RCC_C_SW          3
`define RCC_C_WD          4
`define RCC_CAUSE_RST     5'h02
`define RCC_CAUSE_PORONLY 5'h02

// ----------------------------------------------------------------------------
// brown-out control and watchdog control fields
// ----------------------------------------------------------------------------
`define RCC_BOR_EN        0
`define RCC_BOR_SEL       1
`define RCC_BOR_FLAG      2
`define RCC_WD_RUN        0
`define RCC_WD_RSTEN      1
`define RCC_WD_INTST      2
`define RCC_WD_LOAD_RST   32'hffffffff

// ----------------------------------------------------------------------------
// sequencing counts and bus answers
// ----------------------------------------------------------------------------
`define RCC_SYNC_CYCLES   4'h4
`define RCC_PULSE_CYCLES  4'h2
`define RCC_RESP_OKAY     2'b00
`define RCC_RESP_SLVERR   2'b10

`endif

// ==== verif/rcc_props_properties.sv ====
// assertions on reset sequencing at the ports of the reset cause controller
`timescale 1ns/1ns
module rcc_props #(
  parameter NUM_DOMAINS = 2,
  parameter PRST_W      = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // reset sources
  input wire logic rst_pin_n,
  input wire logic por_detect,
  input wire logic system_reset_request,
  // reset, boot and event outputs
  input wire logic core_reset_n,
  input wire logic periph_reset_n,
  input wire logic tap_reset_n,
  input wire logic boot_fetch_sp,
  input wire logic boot_fetch_pc,
  input wire logic boot_fetch_insn,
  input wire logic core_run,
  input wire logic brownout_int
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------------------
  // release and boot order
  // ----------------------------------------------------------------------------
  sequence boot_s;
    boot_fetch_sp ##1 boot_fetch_pc ##1 boot_fetch_insn;
  endsequence
  a_boot_order: assert property (boot_fetch_sp |-> boot_s) else $error("boot fetch out of order");
  a_rise_fetch: assert property ($rose(core_reset_n) |-> boot_fetch_sp) else $error("release without fetch");
  // pin release must have been seen for several cycles, synchroniser delay included
  a_pin_settle: assert property ($rose(core_reset_n) |-> rst_pin_n && !por_detect && $past(rst_pin_n, 7))
    else $error("release too early");
  a_pin_hold: assert property (!rst_pin_n [*5] |-> !core_reset_n) else $error("pin low but core runs");
  a_periph_core: assert property (periph_reset_n == core_reset_n) else $error("periph reset differs");
  a_tap_keep: assert property (tap_reset_n |=> tap_reset_n) else $error("tap reset again");
  a_bor_pulse: assert property (brownout_int |=> !brownout_int) else $error("brownout event not a pulse");
  a_sw_req: assert property (system_reset_request && core_run |-> ##[1:4] !core_reset_n)
    else $error("request ignored");
endmodule
bind rcc_reset_ctrl rcc_props #(.NUM_DOMAINS(NUM_DOMAINS), .PRST_W(PRST_W)) rcc_props_i (.*);

// ==== verif/rcc_src_model.sv ====
// model of the reset pin, supply monitors and core reset request
`timescale 1ns/1ns
module rcc_src_model (
  // clock
  input  wire logic aclk,
  // reset sources
  output logic      rst_pin_n,
  output logic      por_detect,
  output logic      brown_out_detect,
  output logic      system_reset_request
);
  // power-on detection only at the first power-up, later than the bench reset
  initial begin
    rst_pin_n = 1'b1;
    por_detect = 1'b1;
    brown_out_detect = 1'b0;
    system_reset_request = 1'b0;
    repeat (12) @(posedge aclk);
    por_detect <= 1'b0;
  end
  // source 0 pin, 1 brown-out, 2 core request, active for n cycles
  task pulse(input int s, input int n);
    @(posedge aclk);
    if (s == 0) rst_pin_n <= 1'b0; else if (s == 1) brown_out_detect <= 1'b1; else system_reset_request <= 1'b1;
    repeat (n) @(posedge aclk);
    rst_pin_n <= 1'b1;
    brown_out_detect <= 1'b0;
    system_reset_request <= 1'b0;
  endtask
endmodule

// ==== verif/rcc_reset_ctrl_bench.sv ====
// self-checking bench of the reset cause controller
`timescale 1ns/1ns
`include "rcc_consts.vh"
module rcc_reset_ctrl_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rq;
  logic [1:0] rr;
  wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, core_reset_n, periph_reset_n;
  wire tap_reset_n, boot_fetch_sp, boot_fetch_pc, boot_fetch_insn, core_run, brownout_int, watchdog_int;
  wire rst_pin_n, por_detect, brown_out_detect, system_reset_request;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [191:0] periph_unit_reset;
  wire [2:0] s_axi_awprot = 3'h0;
  wire [2:0] s_axi_arprot = 3'h0;
  wire [3:0] s_axi_wstrb = 4'hf;
  int err_count = 0;
  int n_compared = 0;
  rcc_reset_ctrl rcc_reset_ctrl_i (.*);
  rcc_src_model rcc_src_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // one bus transfer; ready and valid sampled at the falling edge, where they are settled
  task xf(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit ah, wh, dn;
    n = 0;
    dn = 0;
    @(posedge aclk);
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    while (!dn && n < 50) begin
      @(negedge aclk);
      ah = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      wh = s_axi_wvalid && s_axi_wready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      rq = s_axi_rdata;
      rr = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ah) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (wh) s_axi_wvalid <= 1'b0;
      n++;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk("bus answer", 1, dn);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    xf(0, a, 0);
    chk($sformatf("reg %h", a), e, rq);
  endtask
  // bounded wait for the core to leave or enter reset
  task wait_run(input logic v);
    int n;
    n = 0;
    while (core_run !== v && n < 200) begin
      @(negedge aclk);
      n++;
    end
    chk("core_run", v, core_run);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    results;
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    chk("tap", 0, tap_reset_n);
    wait_run(1);
    rd_chk(`RCC_OFS_CAUSE, 32'h02);
    xf(1, `RCC_OFS_CAUSE, 0);
    rd_chk(`RCC_OFS_CAUSE, 32'h00);
    rcc_src_model_i.pulse(0, 6);
    wait_run(1);
    rd_chk(`RCC_OFS_CAUSE, 32'h01);
    chk("tap", 1, tap_reset_n);
    rcc_src_model_i.pulse(1, 6);
    repeat (8) @(negedge aclk);
    chk("core_run", 1, core_run);
    xf(1, `RCC_OFS_BORCTL, 32'h1);
    rcc_src_model_i.pulse(1, 6);
    repeat (8) @(negedge aclk);
    rd_chk(`RCC_OFS_BORCTL, 32'h5);
    xf(1, `RCC_OFS_BORCTL, 32'h3);
    rcc_src_model_i.pulse(1, 20);
    chk("core_run", 0, core_run);
    wait_run(1);
    rd_chk(`RCC_OFS_CAUSE, 32'h05);
    rd_chk(`RCC_OFS_BORCTL, 32'h0);
    rcc_src_model_i.pulse(2, 1);
    wait_run(0);
    wait_run(1);
    rd_chk(`RCC_OFS_CAUSE, 32'h0d);
    // each reset word drives its unit in both clock domains
    for (int k = 0; k < 3; k++) begin
      xf(1, `RCC_OFS_PRST0 + 8'(4 * k), 32'h1 << k);
      repeat (2) @(negedge aclk);
      chk("unit reset", 1, periph_unit_reset[33 * k] & periph_unit_reset[96 + 33 * k]);
      xf(1, `RCC_OFS_PRST0 + 8'(4 * k), 0);
      repeat (2) @(negedge aclk);
      chk("unit reset", 0, |periph_unit_reset);
    end
    xf(1, `RCC_OFS_WDLOAD, 32'h5);
    xf(1, `RCC_OFS_WDCTL, 32'h1);
    repeat (14) @(negedge aclk);
    chk("core_run", 1, core_run);
    chk("wd int", 1, watchdog_int);
    xf(1, `RCC_OFS_WDCTL, 32'h3);
    wait_run(0);
    wait_run(1);
    rd_chk(`RCC_OFS_CAUSE, 32'h1d);
    rd_chk(8'h28, 0);
    chk("resp", 2, rr);
    results;
  end
endmodule
